// ---- src/fpsc_fan_pwm.sv ----
// Fan PWM: spin-up stage, frequency divider and duty value register
`timescale 1ns/1ps
//
// Contract
// - unused upper bits read zero, writes ignored
// - normal spin-up uses duty and time fields
// - fast mode: full duty until timeout or speed
// - fast mode ignores spin-up duty field
// - time code zero skips spin-up entirely
// - duty code none, half, three-quarter, full
// - spin-up time doubles per code from 50ms
// - PWM frequency is master clock over 2n
// - master clock 360 kHz or 1.4 kHz
// - frequency value zero acts as one
// - program clear: value register mirrors table
// - program set: written value drives output
// - value register reads zero during spin-up
// - clock select bit three picks master clock
// - polarity bit sets pull-low sense
// - program bit enables direct value writes
// - automatic mode outputs table entry
module fpsc_fan_pwm #(
  parameter int SPIN_BASE = fpsc_pkg::SPIN_BASE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [5:0] lut_duty,
  input  wire logic       tach_at_speed,
  output logic            pwm_oe,
  output logic            spinup_ff
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  spin_cfg_ff;
  logic [7:0]  freq_ff;
  logic [7:0]  fan_cfg_ff;
  logic [5:0]  man_duty_ff;
  logic [5:0]  cmd_prev_ff;
  logic [31:0] spin_cnt_ff;
  logic [15:0] clk_div_ff;
  logic        tick_ff;

  wire wr_spin = reg_wr && (reg_addr == fpsc_pkg::ADDR_SPINUP_CFG);
  wire wr_freq = reg_wr && (reg_addr == fpsc_pkg::ADDR_FREQ_DIV);
  wire wr_fan  = reg_wr && (reg_addr == fpsc_pkg::ADDR_FAN_CFG);
  wire wr_duty = reg_wr && (reg_addr == fpsc_pkg::ADDR_DUTY_VALUE);
  wire prog_en = fan_cfg_ff[fpsc_pkg::BIT_PROG_EN];
  wire fast    = spin_cfg_ff[fpsc_pkg::BIT_FAST_TACH];
  wire [1:0] sp_duty = spin_cfg_ff[fpsc_pkg::DUTY_MSB:fpsc_pkg::DUTY_LSB];
  wire [2:0] sp_time = spin_cfg_ff[fpsc_pkg::TIME_MSB:fpsc_pkg::TIME_LSB];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      spin_cfg_ff <= fpsc_pkg::RST_SPINUP_CFG;
      freq_ff     <= fpsc_pkg::RST_FREQ_DIV;
      fan_cfg_ff  <= fpsc_pkg::RST_FAN_CFG;
      man_duty_ff <= fpsc_pkg::RST_DUTY_VALUE[5:0];
    end else begin
      if (wr_spin) spin_cfg_ff <= reg_wdata & fpsc_pkg::MASK_SPINUP_CFG;
      if (wr_freq) freq_ff <= reg_wdata & fpsc_pkg::MASK_FREQ_DIV;
      if (wr_fan) fan_cfg_ff <= reg_wdata & fpsc_pkg::MASK_FAN_CFG;
      if (wr_duty && prog_en) man_duty_ff <= reg_wdata[5:0];
    end
  end

  chk_write_taken: assert property (@(posedge clk) disable iff (!rstn)
    (wr_duty && prog_en) |=> man_duty_ff == $past(reg_wdata[5:0]))
    else $error("value write not taken");

  // Commanded duty: table in automatic mode, written value otherwise
  wire [5:0] cmd_duty = prog_en ? man_duty_ff : lut_duty;

  // ****************************************
  // Spin-up
  // ****************************************
  wire [31:0] spin_len  = SPIN_BASE << (sp_time - 3'h1);
  wire        spin_want = (sp_time != fpsc_pkg::SPIN_TIME_OFF) &&
                          (fast || sp_duty != fpsc_pkg::SPIN_DUTY_NONE);
  // Only a 0 -> nonzero command arms spin-up, so duty edits while running never re-spin
  wire        start     = (cmd_prev_ff == 6'h00) && (cmd_duty != 6'h00);
  wire        spin_end  = (spin_cnt_ff >= spin_len - 32'h1) ||
                          (fast && tach_at_speed);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_prev_ff <= 6'h00;
      spinup_ff   <= 1'b0;
      spin_cnt_ff <= 32'h0;
    end else begin
      cmd_prev_ff <= cmd_duty;
      if (spinup_ff) begin
        spin_cnt_ff <= spin_cnt_ff + 32'h1;
        if (spin_end) spinup_ff <= 1'b0;
      end else if (start && spin_want) begin
        spinup_ff   <= 1'b1;
        spin_cnt_ff <= 32'h0;
      end
    end
  end

  // Timeout always ends a spin-up, with or without a tach reading
  chk_spin_timeout: assert property (@(posedge clk) disable iff (!rstn)
    (spinup_ff && spin_cnt_ff >= spin_len - 32'h1) |=> !spinup_ff)
    else $error("spin-up outlived its time");

  // ****************************************
  // Master clock and PWM
  // ****************************************
  wire        slow    = fan_cfg_ff[fpsc_pkg::BIT_CLK_SEL];
  wire [15:0] div_top = slow ? 16'(fpsc_pkg::DIV_SLOW - 1) : 16'(fpsc_pkg::DIV_FAST - 1);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      clk_div_ff <= 16'h0000;
      tick_ff    <= 1'b0;
    end else begin
      tick_ff    <= (clk_div_ff >= div_top);
      clk_div_ff <= (clk_div_ff >= div_top) ? 16'h0000 : clk_div_ff + 16'h0001;
    end
  end

  // After a switch to the fast clock the count may sit above the new top; it wraps next
  chk_divider_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (clk_div_ff >= div_top) |=> (clk_div_ff == 16'h0000 && tick_ff))
    else $error("master divider did not wrap");

  wire [5:0] period2 = {(freq_ff[4:0] == 5'h00) ? 5'h01 : freq_ff[4:0], 1'b0};
  // Full period length forces 100 %; spin duty scales the period
  logic [6:0] spin_level;
  always_comb begin
    case (sp_duty)
      fpsc_pkg::SPIN_DUTY_HALF: spin_level = {2'h0, period2[5:1]};
      fpsc_pkg::SPIN_DUTY_3Q:   spin_level = 7'({1'b0, period2} - {3'h0, period2[5:2]});
      default:                  spin_level = {1'b0, period2};
    endcase
    if (fast) spin_level = {1'b0, period2};
  end
  wire [6:0] duty = spinup_ff ? spin_level : {1'b0, cmd_duty};

  chk_fast_full_duty: assert property (@(posedge clk) disable iff (!rstn)
    (spinup_ff && fast) |-> duty == {1'b0, period2})
    else $error("fast spin-up below full duty");
  chk_half_spin_level: assert property (@(posedge clk) disable iff (!rstn)
    (spinup_ff && !fast && sp_duty == fpsc_pkg::SPIN_DUTY_HALF) |->
      duty == {2'h0, period2[5:1]})
    else $error("half spin-up level wrong");

  logic active;
  fpsc_pwm_gen u_gen (
    .clk    (clk),
    .rstn   (rstn),
    .tick   (tick_ff),
    .freq_n (freq_ff[4:0]),
    .duty   (duty),
    .active (active)
  );

  // Open-drain: oe high pulls the pin low
  always_ff @(posedge clk) begin
    if (!rstn) pwm_oe <= 1'b1;
    else pwm_oe <= fan_cfg_ff[fpsc_pkg::BIT_POLARITY] ? active : ~active;
  end

  chk_polarity_sense: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> pwm_oe == ($past(fan_cfg_ff[fpsc_pkg::BIT_POLARITY]) ?
                        $past(active) : !$past(active)))
    else $error("pin sense does not follow polarity");

  // ****************************************
  // Read back
  // ****************************************
  wire [7:0] duty_rd = spinup_ff ? 8'h00 : {2'h0, cmd_duty};
  always_ff @(posedge clk) begin
    if (!rstn) reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        fpsc_pkg::ADDR_SPINUP_CFG: reg_rdata <= spin_cfg_ff;
        fpsc_pkg::ADDR_FREQ_DIV:   reg_rdata <= freq_ff;
        fpsc_pkg::ADDR_FAN_CFG:    reg_rdata <= fan_cfg_ff;
        fpsc_pkg::ADDR_DUTY_VALUE: reg_rdata <= duty_rd;
        default:                   reg_rdata <= 8'h00;
      endcase
    end
  end

  chk_value_mirror: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == fpsc_pkg::ADDR_DUTY_VALUE && !spinup_ff) |=>
      reg_rdata == {2'h0, $past(cmd_duty)})
    else $error("value read does not show commanded duty");
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr != fpsc_pkg::ADDR_SPINUP_CFG && reg_addr != fpsc_pkg::ADDR_FREQ_DIV &&
     reg_addr != fpsc_pkg::ADDR_FAN_CFG && reg_addr != fpsc_pkg::ADDR_DUTY_VALUE) |=>
      reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ****************************************
  // Checks
  // ****************************************
  chk_spin_read_zero: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == fpsc_pkg::ADDR_DUTY_VALUE && spinup_ff) |=> reg_rdata == 8'h00)
    else $error("value read nonzero in spin-up");
  chk_freq_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
    freq_ff[7:5] == 3'h0 && spin_cfg_ff[7:6] == 2'h0)
    else $error("upper bits not zero");
  chk_skip_time_zero: assert property (@(posedge clk) disable iff (!rstn)
    (sp_time == fpsc_pkg::SPIN_TIME_OFF && !spinup_ff) |=> !spinup_ff)
    else $error("spin-up with time zero");
  chk_fast_tach_end: assert property (@(posedge clk) disable iff (!rstn)
    (spinup_ff && fast && tach_at_speed) |=> !spinup_ff)
    else $error("fast spin-up did not end");
  chk_prog_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr_duty && !prog_en) |=> man_duty_ff == $past(man_duty_ff))
    else $error("write taken while locked");
  chk_spin_start: assert property (@(posedge clk) disable iff (!rstn)
    (!spinup_ff && start && spin_want) |=> spinup_ff)
    else $error("spin-up did not start");
endmodule // fpsc_fan_pwm

// ---- src/fpsc_pkg.sv ----
// Package: register map, field layout, reset values and timing for the fan PWM block
package fpsc_pkg;
  localparam logic [7:0] ADDR_SPINUP_CFG = 8'h4B;
  localparam logic [7:0] ADDR_DUTY_VALUE = 8'h4C;
  localparam logic [7:0] ADDR_FREQ_DIV   = 8'h4D;
  localparam logic [7:0] ADDR_FAN_CFG    = 8'h4A;

  localparam logic [7:0] RST_SPINUP_CFG  = 8'h3F;
  localparam logic [7:0] RST_DUTY_VALUE  = 8'h00;
  localparam logic [7:0] RST_FREQ_DIV    = 8'h17;
  localparam logic [7:0] RST_FAN_CFG     = 8'h20;

  localparam logic [7:0] MASK_SPINUP_CFG = 8'h3F;
  localparam logic [7:0] MASK_DUTY_VALUE = 8'h3F;
  localparam logic [7:0] MASK_FREQ_DIV   = 8'h1F;
  localparam logic [7:0] MASK_FAN_CFG    = 8'h3F;

  localparam int BIT_FAST_TACH  = 5;
  localparam int BIT_PROG_EN    = 5;
  localparam int BIT_POLARITY   = 4;
  localparam int BIT_CLK_SEL    = 3;
  localparam int DUTY_MSB       = 4;
  localparam int DUTY_LSB       = 3;
  localparam int TIME_MSB       = 2;
  localparam int TIME_LSB       = 0;

  localparam logic [1:0] SPIN_DUTY_NONE = 2'h0;
  localparam logic [1:0] SPIN_DUTY_HALF = 2'h1;
  localparam logic [1:0] SPIN_DUTY_3Q   = 2'h2;
  localparam logic [2:0] SPIN_TIME_OFF  = 3'h0;

  // System clock and master PWM clocks, in Hz
  localparam int CLK_HZ        = 10000000;
  localparam int PWM_FAST_HZ   = 360000;
  localparam int PWM_SLOW_HZ   = 1400;
  localparam int DIV_FAST      = CLK_HZ / PWM_FAST_HZ;
  localparam int DIV_SLOW      = CLK_HZ / PWM_SLOW_HZ;
  // Shortest spin-up time in ms; longer codes double it
  localparam int SPIN_BASE_MS  = 50;
  localparam int SPIN_BASE_CYC = CLK_HZ / 1000 * SPIN_BASE_MS;
endpackage

// ---- src/fpsc_pwm_gen.sv ----
// PWM period and duty generator clocked by the master PWM enable
`timescale 1ns/1ps
module fpsc_pwm_gen (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       tick,
  input  wire logic [4:0] freq_n,
  input  wire logic [6:0] duty,
  output logic            active
);
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [5:0] cnt_use;
  logic [4:0] n_eff;
  logic [5:0] period;
  logic       wrap;

  assign n_eff   = (freq_n == 5'h00) ? 5'h01 : freq_n;
  assign period  = {n_eff, 1'b0};
  assign wrap    = (cnt_ff >= period - 6'h01);
  assign nxt_cnt = wrap ? 6'h00 : cnt_ff + 6'h01;
  assign cnt_use = tick ? nxt_cnt : cnt_ff;

  // Duty is compared every clock, not only on a tick, so a new duty (a spin-up
  // start above all) reaches the pin within two clocks instead of a whole tick later
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_ff <= 6'h00;
      active <= 1'b0;
    end else begin
      if (tick) cnt_ff <= nxt_cnt;
      active <= ({1'b0, cnt_use} < duty);
    end
  end

  chk_zero_duty_off: assert property (@(posedge clk) disable iff (!rstn)
    (duty == 7'h00) |=> !active)
    else $error("output active at zero duty");
  chk_full_duty_on: assert property (@(posedge clk) disable iff (!rstn)
    (duty >= {1'b0, period} && (tick || cnt_ff < period)) |=> active)
    else $error("output idle at full duty");
endmodule // fpsc_pwm_gen

// ---- tb/fpsc_fan_model.sv ----
// Behavioural fan on the open-drain PWM pin, with a tach speed flag
`timescale 1ns/1ps
module fpsc_fan_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        pwm_oe,
  input  wire logic        polarity,
  input  wire logic [15:0] spin_need,
  output logic             tach_at_speed
);
  logic [15:0] run_ff;
  logic [7:0]  idle_ff;
  logic        fan_on;
  // Pin pulled low means fan off unless the sense is swapped
  assign fan_on = polarity ? pwm_oe : ~pwm_oe;
  always_ff @(posedge clk) begin
    // A long off stretch lets the rotor coast down to rest
    if (!rstn || idle_ff == 8'hFF) begin
      run_ff <= 16'h0000;
    end else if (fan_on && run_ff != 16'hFFFF) begin
      run_ff <= run_ff + 16'h0001;
    end
    idle_ff <= (!rstn || fan_on) ? 8'h00 : idle_ff + {7'h00, idle_ff != 8'hFF};
  end
  assign tach_at_speed = (run_ff >= spin_need);
endmodule // fpsc_fan_model

// ---- tb/fpsc_fan_pwm_tb.sv ----
// Self-checking bench for the fan PWM block
`timescale 1ns/1ps
module fpsc_fan_pwm_tb;
  localparam int SB = 100;
  localparam int DF = fpsc_pkg::DIV_FAST;
  localparam int DS = fpsc_pkg::DIV_SLOW;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [5:0]  lut_duty = 6'h00;
  logic        tach_at_speed;
  logic        pwm_oe;
  logic        spinup_ff;
  logic        pol = 1'b0;
  logic [15:0] spin_need = 16'h03E8;
  int          fail_count = 0;
  int          check_count = 0;
  int          sp_cnt = 0;
  int          sp_lo = 0;
  int          lo;
  logic [1:0]  sp_d = 2'h0;
  always #50 clk = ~clk;
  fpsc_fan_pwm #(.SPIN_BASE(SB)) uut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lut_duty(lut_duty), .tach_at_speed(tach_at_speed), .pwm_oe(pwm_oe),
    .spinup_ff(spinup_ff));
  fpsc_fan_model fan (.clk(clk), .rstn(rstn), .pwm_oe(pwm_oe), .polarity(pol),
    .spin_need(spin_need), .tach_at_speed(tach_at_speed));
  // Pin lags spin-up by two flops, so its count runs two edges behind
  always @(posedge clk) begin
    sp_d <= {sp_d[0], spinup_ff === 1'b1};
    if (spinup_ff === 1'b1) sp_cnt++;
    if (sp_d[1] && pwm_oe === 1'b0) sp_lo++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // Window is whole PWM periods, so the count does not depend on phase
  task automatic meas(input int n, input int exp);
    lo = 0;
    repeat (n) @(negedge clk);
    repeat (n) begin
      @(negedge clk);
      lo += (pwm_oe === 1'b0);
    end
    chk(16'(lo), 16'(exp));
  endtask
  task automatic spin(input logic [7:0] cfg, input int need, input int lo_d, input int hi_d,
                      input logic full);
    wr(8'h4B, cfg);
    wr(8'h4C, 8'h00);
    spin_need = 16'(need);
    repeat (300) @(negedge clk);
    sp_cnt = 0;
    sp_lo = 0;
    wr(8'h4C, 8'h3F);
    rd(8'h4C, (hi_d > 0) ? 8'h00 : 8'h3F);
    for (int i = 0; i < 3000 && spinup_ff !== 1'b0; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk(16'((sp_cnt >= lo_d) && (sp_cnt <= hi_d)), 16'h0001);
    if (full) chk(16'(sp_lo), 16'(sp_cnt));
  endtask
  // One whole PWM period measured inside a long spin-up
  task automatic spin_duty(input logic [7:0] cfg, input int exp);
    wr(8'h4B, cfg);
    wr(8'h4C, 8'h00);
    repeat (300) @(negedge clk);
    wr(8'h4C, 8'h3F);
    meas(4 * DF, exp);
    chk(16'(spinup_ff), 16'h0001);
    for (int i = 0; i < 3000 && spinup_ff !== 1'b0; i++) @(negedge clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    results();
  end
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    rd(8'h4A, 8'h20);
    rd(8'h4B, 8'h3F);
    rd(8'h4C, 8'h00);
    rd(8'h4D, 8'h17);
    rd(8'h4E, 8'h00);
    wr(8'h4B, 8'hFF);
    rd(8'h4B, 8'h3F);
    wr(8'h4D, 8'hFF);
    rd(8'h4D, 8'h1F);
    wr(8'h4B, 8'h38);
    wr(8'h4D, 8'h01);
    sp_cnt = 0;
    wr(8'h4C, 8'h01);
    meas(2 * DF, DF);
    chk(16'(sp_cnt), 16'h0000);
    wr(8'h4D, 8'h00);
    meas(2 * DF, DF);
    wr(8'h4C, 8'h02);
    meas(2 * DF, 2 * DF);
    pol = 1'b1;
    wr(8'h4A, 8'h30);
    meas(2 * DF, 0);
    pol = 1'b0;
    wr(8'h4A, 8'h28);
    wr(8'h4C, 8'h01);
    meas(2 * DS, DS);
    wr(8'h4A, 8'h00);
    lut_duty = 6'h2A;
    rd(8'h4C, 8'h2A);
    wr(8'h4C, 8'h05);
    rd(8'h4C, 8'h2A);
    wr(8'h4A, 8'h20);
    spin(8'h0A, 1000, 2 * SB, 2 * SB, 1'b0);
    spin(8'h1C, 1000, 8 * SB, 8 * SB, 1'b1);
    spin(8'h02, 1000, 0, 0, 1'b0);
    spin(8'h21, 1000, SB, SB, 1'b1);
    // Multi-function pin taken as tach input for the next run
    spin(8'h23, 40, 40, 46, 1'b1);
    wr(8'h4D, 8'h02);
    spin_duty(8'h0C, 2 * DF);
    spin_duty(8'h14, 3 * DF);
    results();
  end
endmodule // fpsc_fan_pwm_tb
